// ==== isv_core_model.sv ====
`timescale 1ns/100ps
// core side: takes a standing request after lag cycles
module isv_core_model (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // bench control
    input wire logic accept,
    input wire logic [1:0] lag,
    // request handshake
    input wire logic irq_req,
    output logic irq_ack
);
    logic [1:0] cnt_q;
    // one-cycle ack pulse, never two in a row
    always_ff @(posedge aclk) begin
        if (!aresetn || !accept || !irq_req || irq_ack) begin
            cnt_q <= 2'h0;
            irq_ack <= 1'h0;
        end else if (cnt_q == lag) begin
            irq_ack <= 1'h1;
        end else begin
            cnt_q <= cnt_q + 2'h1;
        end
    end
endmodule : isv_core_model

// ==== isv_pkg.sv ====
package isv_pkg;
    typedef enum logic [1:0] {ISV_LOW, ISV_FALL, ISV_RISE, ISV_BOTH} isv_sense_t;
    typedef enum logic {ISV_FLAT, ISV_LEVEL} isv_mode_t;
    // pin detector state
    typedef struct packed {
        logic s1;
        logic s2;
        logic prev;
        logic hit;
    } isv_sync_t;
    // controller state
    typedef struct packed {
        logic nmi_edge_select;
        logic [1:0] intm;
        logic [15:0] pin_sense_config;
        logic [7:0] pin_request_enable;
        logic [7:0] pin_request_flags;
        logic [8:0][1:0][2:0] priority_level_fields;
        logic nmi_pend;
        logic req;
        logic [7:0] vec;
        logic [2:0] lvl;
        logic wake;
        logic aw_ok;
        logic [7:0] aw_addr;
        logic w_ok;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } isv_state_t;
endpackage : isv_pkg

// ==== isv_regs.svh ====
`ifndef ISV_REGS_SVH
`define ISV_REGS_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define ISV_SYSTEM_CONTROL_REG_OFS 8'h00
`define ISV_PIN_SENSE_CONFIG_OFS 8'h04
`define ISV_PIN_REQUEST_ENABLE_OFS 8'h08
`define ISV_PIN_REQUEST_FLAGS_OFS 8'h0C
`define ISV_PRIO_BASE_OFS 8'h10
`define ISV_PRIO_LAST_OFS 8'h30
`define ISV_STATUS_OFS 8'h34

// ----------------------------------------
// field positions and reset values
// ----------------------------------------
`define ISV_EDGE_BIT 0
`define ISV_MODE_LSB 4
`define ISV_PRIO_HI_LSB 4
`define ISV_PRIO_LO_LSB 0
`define ISV_STAT_LVL_LSB 8
`define ISV_STAT_REQ_BIT 16
`define ISV_STAT_NMI_BIT 17
`define ISV_STAT_WAKE_BIT 18
`define ISV_PRIO_RST 3'h7
`define ISV_MODE_LEVEL 2'h2

// ----------------------------------------
// vector numbers
// ----------------------------------------
`define ISV_VEC_NMI 8'h07
`define ISV_VEC_PIN0 8'h10
`define ISV_VEC_SOFTEND 8'h18
`define ISV_VEC_WDOG 8'h19
`define ISV_VEC_TMR0 8'h20
`define ISV_VEC_TMR1 8'h28
`define ISV_VEC_TMR2 8'h2C
`define ISV_VEC_DMA 8'h48
`define ISV_VEC_SER0 8'h50
`define ISV_VEC_EXP0 8'h68

`endif

// ==== isv_sense.sv ====
`timescale 1ns/100ps
module isv_sense
    import isv_pkg::*;
(
    // clock and control
    input logic aclk,
    input logic aresetn,
    input logic ce,
    // pin and condition
    input logic pin,
    input isv_sense_t mode,
    // results
    output logic hit,
    output logic level
);
    isv_sync_t st_q;
    isv_sync_t st_d;

    // two-stage synchroniser, then condition detect
    always_comb begin
        st_d = st_q;
        st_d.s1 = pin;
        st_d.s2 = st_q.s1;
        st_d.prev = st_q.s2;
        unique case (mode)
            ISV_LOW: st_d.hit = !st_q.s2;
            ISV_FALL: st_d.hit = st_q.prev && !st_q.s2;
            ISV_RISE: st_d.hit = !st_q.prev && st_q.s2;
            ISV_BOTH: st_d.hit = st_q.prev ^ st_q.s2;
        endcase
    end

    // idle-high pins: reset to 1 avoids a false edge
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_q <= '{s1: 1'b1, s2: 1'b1, prev: 1'b1, hit: 1'b0};
        end else if (ce) begin
            st_q <= st_d;
        end
    end

    assign hit = st_q.hit;
    assign level = st_q.s2;
endmodule : isv_sense

// ==== isv_top.sv ====
// Contract
// - nmi is top priority, presented regardless of mode or core mask
// - nmi requested on rising or falling pin edge per edge select
// - nmi supplies vector 7
// - each request pin senses low level, falling, rising or both edges
// - request pins 0 to 7 get vectors 16 to 23
// - pin detection ignores the pin direction setting
// - pin flag sets on its condition even when disabled
// - only nmi and request pins 0 to 2 wake from standby
// - expansion pin driven low raises its interrupt
// - peripheral request forwarded only when flag and enable are both 1
// - transfer-engine acceptance leaves control mode and core mask alone
// - default priority: lower vector number ranks higher
// - equal programmed levels resolved by fixed vector ranking
// - vector address is four times the vector number, 16 bits
// - soft transfer end uses vector 24, field lo of third register
// - timer channel 0: vectors 32 to 36, one field, 37-39 reserved
// - timer channel 1: vectors 40 to 43, one shared field
// - timer channel 2: vectors 44 to 47, one shared field
// - dma ends: vectors 72 to 75, one shared field
// - serial channels: four vectors each from 80 to 91
// - expansion pins: vectors 104 to 111, two fields of four
// - 3-bit levels, 0 lowest 7 highest, fields at bits 6:4 and 2:0
// - highest level passed only when above core mask level
// - flat mode: mask bit 1 passes only nmi, others stay pending
`timescale 1ns/100ps
`include "isv_regs.svh"
module isv_top
    import isv_pkg::*;
#(
    parameter int ADDR_W = 8,
    parameter int NPER = 31
) (
    // clock and reset
    input logic aclk,
    input logic aresetn,
    input logic ce,
    input logic hw_standby,
    input logic standby,
    // register bus write
    input logic [ADDR_W-1:0] s_axi_awaddr,
    input logic s_axi_awvalid,
    output logic s_axi_awready,
    input logic [31:0] s_axi_wdata,
    input logic [3:0] s_axi_wstrb,
    input logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input logic s_axi_bready,
    // register bus read
    input logic [ADDR_W-1:0] s_axi_araddr,
    input logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input logic s_axi_rready,
    // pins
    input logic nmi_pin,
    input logic [7:0] irq_pin_n,
    input logic [7:0] expansion_request_pins_n,
    // on-chip peripherals
    input logic [NPER-1:0] periph_flag,
    input logic [NPER-1:0] periph_en,
    // processor core
    input logic core_mask,
    input logic [2:0] core_level,
    input logic irq_ack,
    input logic xfer_ack,
    output logic irq_req,
    output logic [7:0] irq_vector,
    output logic [15:0] irq_vaddr,
    output logic [2:0] irq_level,
    output logic wake
);
    localparam int NSRC = 47;
    localparam int NPIN = 17;

    // ----------------------------------------
    // source table
    // ----------------------------------------
    // vector of maskable source i, ascending with i
    function automatic logic [7:0] src_vec(input int i);
        if (i < 8) return `ISV_VEC_PIN0 + 8'(i);
        if (i == 8) return `ISV_VEC_SOFTEND;
        if (i == 9) return `ISV_VEC_WDOG;
        if (i < 15) return `ISV_VEC_TMR0 + 8'(i - 10);
        if (i < 19) return `ISV_VEC_TMR1 + 8'(i - 15);
        if (i < 23) return `ISV_VEC_TMR2 + 8'(i - 19);
        if (i < 27) return `ISV_VEC_DMA + 8'(i - 23);
        if (i < 39) return `ISV_VEC_SER0 + 8'(i - 27);
        return `ISV_VEC_EXP0 + 8'(i - 39);
    endfunction : src_vec

    // priority field: register*2, even = bits 6:4, odd = bits 2:0
    function automatic int src_fld(input int i);
        if (i < 2) return i;
        if (i < 8) return 1 + i / 2;
        if (i == 8) return 5;
        if (i == 9) return 6;
        if (i < 15) return 8;
        if (i < 19) return 9;
        if (i < 23) return 10;
        if (i < 27) return 12;
        if (i < 39) return 13 + (i - 27) / 4;
        return 16 + (i - 39) / 4;
    endfunction : src_fld

    isv_state_t st_q;
    isv_state_t st_d;
    isv_state_t st_rst;
    logic [NPIN-1:0] pins;
    logic [NPIN-1:0][1:0] modes;
    logic [NPIN-1:0] hit;
    logic [NPIN-1:0] lvl;
    logic [NSRC-1:0] req;
    logic level_mode;
    logic wr_fire;
    logic sel_ok;
    logic [7:0] sel_v;
    logic [2:0] sel_l;
    logic [2:0] lv;
    logic [7:0] wclr;
    logic [7:0] aclr;
    logic [7:0] ra;
    logic [3:0] pidx;
    logic [7:0] widx;

    // ----------------------------------------
    // pin detectors
    // ----------------------------------------
    // slot 0 nmi, 1-8 request pins, 9-16 expansion pins
    assign pins = {expansion_request_pins_n, irq_pin_n, nmi_pin};
    always_comb begin
        modes[0] = st_q.nmi_edge_select ? ISV_RISE : ISV_FALL;
        for (int n = 0; n < 8; n++) begin
            modes[n + 1] = st_q.pin_sense_config[2 * n +: 2];
            modes[n + 9] = ISV_LOW;
        end
    end

    for (genvar g = 0; g < NPIN; g++) begin : g_pin
        isv_sense u_sense (
            .aclk(aclk),
            .aresetn(aresetn && !hw_standby),
            .ce(ce),
            .pin(pins[g]),
            .mode(isv_sense_t'(modes[g])),
            .hit(hit[g]),
            .level(lvl[g])
        );
    end

    // ----------------------------------------
    // request vector
    // ----------------------------------------
    assign level_mode = (st_q.intm == `ISV_MODE_LEVEL);
    assign req[7:0] = st_q.pin_request_flags & st_q.pin_request_enable;
    assign req[38:8] = periph_flag & periph_en;
    assign req[46:39] = hit[16:9];

    // bus handshakes
    assign s_axi_awready = ce && !st_q.aw_ok;
    assign s_axi_wready = ce && !st_q.w_ok;
    assign s_axi_arready = ce && !st_q.rvalid;
    assign wr_fire = st_q.aw_ok && st_q.w_ok && !st_q.bvalid;
    assign ra = 8'(s_axi_araddr);
    assign pidx = 4'((ra - `ISV_PRIO_BASE_OFS) >> 2);
    assign widx = 8'((st_q.aw_addr - `ISV_PRIO_BASE_OFS) >> 2);

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        st_d = st_q;
        sel_ok = 1'b0;
        sel_v = 8'h00;
        sel_l = 3'h0;
        lv = 3'h0;
        wclr = 8'h00;
        aclr = 8'h00;
        // write path: address and data in either order
        if (s_axi_awvalid && s_axi_awready) begin
            st_d.aw_ok = 1'b1;
            st_d.aw_addr = 8'(s_axi_awaddr);
        end
        if (s_axi_wvalid && s_axi_wready) begin
            st_d.w_ok = 1'b1;
            st_d.wdata = s_axi_wdata;
            st_d.wstrb = s_axi_wstrb;
        end
        if (st_q.bvalid && s_axi_bready) begin
            st_d.bvalid = 1'b0;
        end
        if (wr_fire) begin
            st_d.aw_ok = 1'b0;
            st_d.w_ok = 1'b0;
            st_d.bvalid = 1'b1;
            st_d.bresp = 2'h0;
            unique case (st_q.aw_addr)
                `ISV_SYSTEM_CONTROL_REG_OFS: begin
                    if (st_q.wstrb[0]) begin
                        st_d.nmi_edge_select = st_q.wdata[`ISV_EDGE_BIT];
                        st_d.intm = st_q.wdata[`ISV_MODE_LSB +: 2];
                    end
                end
                `ISV_PIN_SENSE_CONFIG_OFS: begin
                    if (st_q.wstrb[0]) st_d.pin_sense_config[7:0] = st_q.wdata[7:0];
                    if (st_q.wstrb[1]) st_d.pin_sense_config[15:8] = st_q.wdata[15:8];
                end
                `ISV_PIN_REQUEST_ENABLE_OFS: begin
                    if (st_q.wstrb[0]) st_d.pin_request_enable = st_q.wdata[7:0];
                end
                `ISV_PIN_REQUEST_FLAGS_OFS: begin
                    // only zeros act: they clear
                    if (st_q.wstrb[0]) wclr = ~st_q.wdata[7:0];
                end
                `ISV_STATUS_OFS: begin
                end
                default: begin
                    if (st_q.aw_addr >= `ISV_PRIO_BASE_OFS && st_q.aw_addr <= `ISV_PRIO_LAST_OFS
                        && st_q.aw_addr[1:0] == 2'h0) begin
                        if (st_q.wstrb[0]) begin
                            st_d.priority_level_fields[widx[3:0]][1] =
                                st_q.wdata[`ISV_PRIO_HI_LSB +: 3];
                            st_d.priority_level_fields[widx[3:0]][0] =
                                st_q.wdata[`ISV_PRIO_LO_LSB +: 3];
                        end
                    end else begin
                        st_d.bresp = 2'h2;
                    end
                end
            endcase
        end
        // read path
        if (st_q.rvalid && s_axi_rready) begin
            st_d.rvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            st_d.rvalid = 1'b1;
            st_d.rresp = 2'h0;
            st_d.rdata = 32'h0000_0000;
            unique case (ra)
                `ISV_SYSTEM_CONTROL_REG_OFS: begin
                    st_d.rdata[`ISV_EDGE_BIT] = st_q.nmi_edge_select;
                    st_d.rdata[`ISV_MODE_LSB +: 2] = st_q.intm;
                end
                `ISV_PIN_SENSE_CONFIG_OFS: st_d.rdata[15:0] = st_q.pin_sense_config;
                `ISV_PIN_REQUEST_ENABLE_OFS: st_d.rdata[7:0] = st_q.pin_request_enable;
                `ISV_PIN_REQUEST_FLAGS_OFS: st_d.rdata[7:0] = st_q.pin_request_flags;
                `ISV_STATUS_OFS: begin
                    st_d.rdata[7:0] = st_q.vec;
                    st_d.rdata[`ISV_STAT_LVL_LSB +: 3] = st_q.lvl;
                    st_d.rdata[`ISV_STAT_REQ_BIT] = st_q.req;
                    st_d.rdata[`ISV_STAT_NMI_BIT] = st_q.nmi_pend;
                    st_d.rdata[`ISV_STAT_WAKE_BIT] = st_q.wake;
                end
                default: begin
                    if (ra >= `ISV_PRIO_BASE_OFS && ra <= `ISV_PRIO_LAST_OFS && ra[1:0] == 2'h0) begin
                        // unused bits 7 and 3 read as 1
                        st_d.rdata[7:0] = {1'b1, st_q.priority_level_fields[pidx][1],
                            1'b1, st_q.priority_level_fields[pidx][0]};
                    end else begin
                        st_d.rresp = 2'h2;
                    end
                end
            endcase
        end
        // acceptance clears the presented pin source, a low-level pin only once it reads high
        for (int n = 0; n < 8; n++) begin
            if ((irq_ack || xfer_ack) && st_q.vec == `ISV_VEC_PIN0 + 8'(n)
                && (st_q.pin_sense_config[2 * n +: 2] != 2'h0 || lvl[n + 1])) begin
                aclr[n] = 1'b1;
            end
        end
        // set wins over clear
        st_d.pin_request_flags = hit[8:1] | (st_q.pin_request_flags & ~(wclr | aclr));
        st_d.nmi_pend = hit[0] || (st_q.nmi_pend && !(irq_ack && st_q.vec == `ISV_VEC_NMI));
        // control mode untouched by transfer-engine acceptance
        // priority selection, ascending vectors, strict compare keeps ties
        for (int i = 0; i < NSRC; i++) begin
            lv = st_q.priority_level_fields[src_fld(i) / 2][1 - src_fld(i) % 2];
            if (req[i] && (level_mode ? (lv > core_level) : !core_mask)) begin
                if (!sel_ok || (level_mode && lv > sel_l)) begin
                    sel_ok = 1'b1;
                    sel_l = lv;
                    sel_v = src_vec(i);
                end
            end
        end
        // nmi overrides everything; losers simply stay pending
        if (st_q.nmi_pend) begin
            st_d.req = 1'b1;
            st_d.vec = `ISV_VEC_NMI;
            st_d.lvl = 3'h7;
        end else begin
            st_d.req = sel_ok;
            st_d.vec = sel_ok ? sel_v : st_q.vec;
            st_d.lvl = sel_ok ? sel_l : st_q.lvl;
        end
        if (irq_ack || xfer_ack) begin
            st_d.req = 1'b0;
        end
        // wake sources limited to nmi and pins 0 to 2
        st_d.wake = standby && (st_q.nmi_pend
            || |(st_q.pin_request_flags[2:0] & st_q.pin_request_enable[2:0]));
    end

    // ----------------------------------------
    // state register
    // ----------------------------------------
    always_comb begin
        st_rst = '0;
        st_rst.priority_level_fields = {18{`ISV_PRIO_RST}};
    end

    always_ff @(posedge aclk) begin
        if (!aresetn || hw_standby) begin
            st_q <= st_rst;
        end else if (ce) begin
            st_q <= st_d;
        end
    end

    // outputs
    assign s_axi_bvalid = st_q.bvalid;
    assign s_axi_bresp = st_q.bresp;
    assign s_axi_rvalid = st_q.rvalid;
    assign s_axi_rdata = st_q.rdata;
    assign s_axi_rresp = st_q.rresp;
    assign irq_req = st_q.req;
    assign irq_vector = st_q.vec;
    assign irq_vaddr = {6'h00, st_q.vec, 2'h0};
    assign irq_level = st_q.lvl;
    assign wake = st_q.wake;

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn || hw_standby);

    sequence exp_low_s;
        ce && !expansion_request_pins_n[0] [*4];
    endsequence

    sequence nmi_seen_s;
        ce && st_q.nmi_pend && !irq_ack && !xfer_ack;
    endsequence

    nmi_first_a: assert property (nmi_seen_s |=> irq_req && irq_vector == 8'h07
        && irq_level == 3'h7)
        else $error("nmi not presented first");
    nmi_edge_a: assert property (ce && hit[0] |=> st_q.nmi_pend)
        else $error("nmi edge lost");
    exp_low_a: assert property (exp_low_s |-> hit[9])
        else $error("expansion low not seen");
    flag_set_a: assert property (ce && hit[8:1] != 8'h00
        |=> (st_q.pin_request_flags & $past(hit[8:1])) == $past(hit[8:1]))
        else $error("pin flag not set");
    flat_mask_a: assert property (ce && !level_mode && core_mask && !st_q.nmi_pend
        |=> !irq_req)
        else $error("masked request passed");
    level_gate_a: assert property (ce && level_mode && !st_q.nmi_pend
        |=> !irq_req || irq_level > $past(core_level))
        else $error("level not above mask");
    periph_gate_a: assert property (ce && !st_q.nmi_pend ##1 irq_req && irq_vector == 8'h18
        |-> $past(periph_flag[0] && periph_en[0]))
        else $error("disabled peripheral passed");
    wake_src_a: assert property (ce && (!standby || (!st_q.nmi_pend
        && (st_q.pin_request_flags[2:0] & st_q.pin_request_enable[2:0]) == 3'h0)) |=> !wake)
        else $error("wake from wrong source");
    pend_keep_a: assert property (ce && !irq_ack && !xfer_ack && !wr_fire
        |=> (st_q.pin_request_flags & $past(st_q.pin_request_flags)) == $past(st_q.pin_request_flags))
        else $error("pending flag lost");
    xfer_mode_a: assert property (ce && xfer_ack && !wr_fire |=> $stable(st_q.intm))
        else $error("transfer acceptance changed mode");
    vaddr_a: assert property (irq_req |-> irq_vaddr[9:2] == irq_vector && irq_vaddr[1:0] == 2'h0)
        else $error("vector address wrong");
endmodule : isv_top

// ==== isv_top_bench.sv ====
`timescale 1ns/100ps
`include "isv_regs.svh"
module isv_top_bench;
    logic aclk = 1'h0, aresetn = 1'h0, hws = 1'h0, stby = 1'h0;
    logic awv = 1'h0, wv = 1'h0, bry = 1'h0, arv = 1'h0, rry = 1'h0;
    logic awrdy, wrdy, bv, arrdy, rv, req, ack, wake, st;
    logic [7:0] awa = 8'h00, ara = 8'h00, vec;
    logic [31:0] wd = 32'h0, rdat, rval;
    logic [1:0] bresp, rresp, resp;
    logic nmi = 1'h1, cmask = 1'h0, xack = 1'h0, accept = 1'h0;
    logic [7:0] irqn = 8'hFF, expn = 8'hFF;
    logic [30:0] pflag = 31'h0, pen = 31'h0;
    logic [2:0] clvl = 3'h0, lvl;
    logic [1:0] lag = 2'h0;
    logic [15:0] vaddr;
    logic [28:0] smp_q;
    int err_count = 0, tests_run = 0, n;
    int pidx[12] = '{0, 1, 2, 6, 7, 10, 11, 14, 15, 18, 19, 30};
    logic [7:0] pvec[12] = '{8'h18, 8'h19, 8'h20, 8'h24, 8'h28, 8'h2B, 8'h2C, 8'h2F, 8'h48, 8'h4B, 8'h50, 8'h5B};

    always #5 aclk = ~aclk;

    isv_top uut (.aclk(aclk), .aresetn(aresetn), .ce(1'h1), .hw_standby(hws), .standby(stby),
        .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awrdy), .s_axi_wdata(wd),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wrdy), .s_axi_bresp(bresp),
        .s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arvalid(arv),
        .s_axi_arready(arrdy), .s_axi_rdata(rdat), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
        .s_axi_rready(rry), .nmi_pin(nmi), .irq_pin_n(irqn), .expansion_request_pins_n(expn),
        .periph_flag(pflag), .periph_en(pen), .core_mask(cmask), .core_level(clvl),
        .irq_ack(ack), .xfer_ack(xack), .irq_req(req), .irq_vector(vec), .irq_vaddr(vaddr),
        .irq_level(lvl), .wake(wake));

    isv_core_model core (.aclk(aclk), .aresetn(aresetn), .accept(accept), .lag(lag),
        .irq_req(req), .irq_ack(ack));

    // ----------------------------------------
    // reporting and bus tasks
    // ----------------------------------------
    task automatic end_sim();
        $display("comparisons %0d, mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : end_sim

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
            err_count++;
        end
    endtask : chk

    task automatic lim(input logic ok);
        if (!ok) begin
            err_count++;
            end_sim();
        end
    endtask : lim

    task automatic idle(input int c);
        repeat (c) @(posedge aclk);
    endtask : idle

    // settled outputs taken at the falling edge
    task automatic smp();
        @(negedge aclk);
        smp_q = {req, vec, vaddr, lvl, wake};
        @(posedge aclk);
    endtask : smp

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int i;
        logic ta, tw, g, pa, pw;
        awa <= a;
        wd <= d;
        awv <= 1'h1;
        wv <= 1'h1;
        // local copies: the valids read back only after their update lands
        pa = 1'h1;
        pw = 1'h1;
        for (i = 0; i < 40 && (pa || pw); i++) begin
            @(negedge aclk);
            ta = pa && awrdy;
            tw = pw && wrdy;
            @(posedge aclk);
            if (ta) awv <= 1'h0;
            if (tw) wv <= 1'h0;
            pa = pa && !ta;
            pw = pw && !tw;
        end
        lim(!pa && !pw);
        bry <= 1'h1;
        i = 0;
        do begin
            @(negedge aclk);
            g = bv;
            resp = bresp;
            @(posedge aclk);
            i++;
        end while (!g && i < 40);
        lim(g);
        bry <= 1'h0;
    endtask : wr

    task automatic rd(input logic [7:0] a);
        int i;
        logic t, g;
        ara <= a;
        arv <= 1'h1;
        rry <= 1'h1;
        i = 0;
        do begin
            @(negedge aclk);
            t = arv && arrdy;
            g = rv;
            rval = rdat;
            resp = rresp;
            @(posedge aclk);
            if (t) arv <= 1'h0;
            i++;
        end while (!g && i < 40);
        lim(g);
        // rready stays high between reads
    endtask : rd

    // waits for a request, checks its vector and address
    task automatic present(input logic [7:0] v);
        int i;
        // pin path needs five edges before a new vector shows
        idle(5);
        i = 0;
        do begin
            smp();
            i++;
        end while (smp_q[28] !== 1'h1 && i < 20);
        lim(smp_q[28] === 1'h1);
        chk(32'(smp_q[27:20]), 32'(v));
        chk(32'(smp_q[19:4]), {22'h0, v, 2'h0});
    endtask : present

    task automatic take();
        accept <= 1'h1;
        idle(6);
        accept <= 1'h0;
    endtask : take

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        idle(3);
        aresetn <= 1'h1;
        rd(`ISV_PRIO_BASE_OFS);
        chk(rval, 32'h000000FF);
        rd(8'h38);
        chk(32'(resp), 32'h2);
        wr(8'h38, 32'h0);
        chk(32'(resp), 32'h2);
        cmask <= 1'h1;
        nmi <= 1'h0;
        present(8'h07);
        take();
        wr(`ISV_SYSTEM_CONTROL_REG_OFS, 32'h1);
        chk(32'(resp), 32'h0);
        lag <= 2'h3;
        nmi <= 1'h1;
        present(8'h07);
        take();
        nmi <= 1'h0;
        idle(6);
        smp();
        chk(32'(smp_q[28]), 32'h0);
        cmask <= 1'h0;
        wr(`ISV_SYSTEM_CONTROL_REG_OFS, 32'h0);
        stby <= 1'h1;
        for (n = 0; n < 8; n++) begin
            st = (n % 4 != 2);
            wr(`ISV_PIN_SENSE_CONFIG_OFS, 32'(n % 4) << (2 * n));
            irqn[n] <= st;
            idle(6);
            wr(`ISV_PIN_REQUEST_FLAGS_OFS, 32'h0);
            irqn[n] <= !st;
            idle(6);
            rd(`ISV_PIN_REQUEST_FLAGS_OFS);
            chk(rval, 32'h1 << n);
            irqn[n] <= st;
            idle(6);
            wr(`ISV_PIN_REQUEST_FLAGS_OFS, 32'h0);
            wr(`ISV_PIN_REQUEST_ENABLE_OFS, 32'h1 << n);
            irqn[n] <= !st;
            present(8'h10 + 8'(n));
            smp();
            chk(32'(smp_q[0]), 32'(n < 3));
            if (n == 7) begin
                xack <= 1'h1;
                idle(1);
                xack <= 1'h0;
                rd(`ISV_SYSTEM_CONTROL_REG_OFS);
                chk(rval, 32'h0);
            end else begin
                take();
            end
            irqn[n] <= 1'h1;
            idle(6);
            wr(`ISV_PIN_REQUEST_FLAGS_OFS, 32'h0);
            wr(`ISV_PIN_REQUEST_ENABLE_OFS, 32'h0);
        end
        stby <= 1'h0;
        // each peripheral group, flat mode
        for (n = 0; n < 12; n++) begin
            pflag <= 31'h1 << pidx[n];
            pen <= 31'h1 << pidx[n];
            present(pvec[n]);
        end
        expn[5] <= 1'h0;
        present(8'h5B);
        cmask <= 1'h1;
        idle(4);
        smp();
        chk(32'(smp_q[28]), 32'h0);
        cmask <= 1'h0;
        pen <= 31'h0;
        present(8'h6D);
        expn[0] <= 1'h0;
        present(8'h68);
        expn <= 8'hFF;
        // level mode
        wr(`ISV_SYSTEM_CONTROL_REG_OFS, 32'h20);
        wr(8'h18, 32'h03);
        wr(8'h20, 32'h50);
        pflag <= 31'h5;
        pen <= 31'h5;
        clvl <= 3'h2;
        present(8'h20);
        chk(32'(smp_q[3:1]), 32'h5);
        rd(`ISV_STATUS_OFS);
        chk(rval, 32'h00010520);
        clvl <= 3'h5;
        idle(4);
        smp();
        chk(32'(smp_q[28]), 32'h0);
        wr(8'h20, 32'h30);
        clvl <= 3'h2;
        present(8'h18);
        pflag <= 31'h4;
        present(8'h20);
        hws <= 1'h1;
        idle(1);
        hws <= 1'h0;
        rd(`ISV_SYSTEM_CONTROL_REG_OFS);
        chk(rval, 32'h0);
        end_sim();
    end
endmodule : isv_top_bench
